/* File: shared/slot_status_regs.vh */
`ifndef SLOT_STATUS_REGS_VH
`define SLOT_STATUS_REGS_VH
// ==========================================================
// Slot status register map
`define SLOT_STATUS_OFFSET 8'hBA
`define SLOT_STATUS_RESET 16'h0000
`define SLOT_STATUS_WIDTH 16
`define BUTTON_PRESSED_BIT 0
`define POWER_FAULT_BIT 1
`define LATCH_SENSOR_CHANGED_BIT 2
`define PRESENCE_CHANGED_BIT 3
`define PRESENCE_STATE_BIT 6
`endif

/* File: hw/pcie_slot_status_register.v */
`include "slot_status_regs.vh"
`default_nettype none
// Contract
// - Presence state is in-band OR out-of-band detect.
// - Presence state: zero empty, one present.
// - No slot implemented forces presence state one.
// - In-band detect counts only while adapter powered.
// - Presence change sets write-one-to-clear flag.
// - Latch sensor change sets flag when present.
// - Power fault sets flag when detection supported.
// - Power fault accepted anytime, any slot state.
// - Button press sets flag when button present.
// - Whole register resets to zero.
// - Enabled presence change notifies software.
module pcie_slot_status_register (
   input wire clk,
   input wire nrst,
   input wire slot_implemented,
   input wire inband_presence,
   input wire oob_presence_present,
   input wire oob_presence,
   input wire adapter_powered,
   input wire latch_sensor_present,
   input wire latch_sensor,
   input wire fault_detect_supported,
   input wire power_fault,
   input wire button_present,
   input wire button,
   input wire presence_change_notify_enable,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [7:0] cfg_addr,
   input wire [1:0] cfg_byte_en,
   input wire [15:0] cfg_wdata,
   output reg [15:0] cfg_rdata,
   output reg cfg_rd_ack,
   output reg presence_change_notify
);
   // ==========================================================
   // Reset release
   reg rst_sync1;
   reg rst_n;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_n <= rst_sync1;
      end
   end

   // ==========================================================
   // Slot state and event flags
   reg presence_state;
   reg presence_changed_flag;
   reg sampler_armed;
   reg latch_sensor_prev;
   reg button_prev;
   reg [15:0] next_rdata;
   wire next_presence_state;
   wire inband_seen;
   wire oob_seen;
   wire set_presence;
   wire reg_hit;
   wire hit_wr;
   wire hit_rd;
   wire clear_presence;
   wire latch_sensor_changed_flag;
   wire power_fault_flag;
   wire button_pressed_flag;
   wire [2:0] event_capable;
   wire [2:0] event_hit;
   wire [2:0] event_flags;
   wire [15:0] status_word;

   // ==========================================================
   // Presence detection

   // In-band detect is meaningless without adapter power, so it is gated here.
   assign inband_seen = inband_presence & adapter_powered;

   // The out-of-band path only counts where the form factor provides one.
   assign oob_seen = oob_presence_present & oob_presence;

   // A port without a slot must look occupied to software.
   assign next_presence_state = slot_implemented ?
      (inband_seen | oob_seen) :
      1'b1;

   assign set_presence = next_presence_state != presence_state;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presence_state <= 1'b0;
      end else begin
         presence_state <= next_presence_state;
      end
   end

   // A change arriving with the clear wins, so no event is lost.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presence_changed_flag <= 1'b0;
      end else if (set_presence) begin
         presence_changed_flag <= 1'b1;
      end else if (clear_presence) begin
         presence_changed_flag <= 1'b0;
      end
   end

   // One pulse per change, even when the flag is already set.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presence_change_notify <= 1'b0;
      end else begin
         presence_change_notify <= set_presence & presence_change_notify_enable;
      end
   end

   // ==========================================================
   // Sensor history

   // The first sample after reset only primes the edge detectors.
   // Comparing it with the reset value of a history flop would report a
   // false change whenever a sensor idles high.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampler_armed <= 1'b0;
      end else begin
         sampler_armed <= 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_sensor_prev <= 1'b0;
      end else begin
         latch_sensor_prev <= latch_sensor;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         button_prev <= 1'b0;
      end else begin
         button_prev <= button;
      end
   end

   // ==========================================================
   // Sticky event flags

   // Capabilities are levels, so a source that is absent never sets its flag.
   assign event_capable = {latch_sensor_present, fault_detect_supported, button_present};

   assign event_hit[`BUTTON_PRESSED_BIT] =
      sampler_armed & button & ~button_prev;

   // A fault is taken on every cycle it is seen, whatever the slot state.
   assign event_hit[`POWER_FAULT_BIT] = power_fault;

   assign event_hit[`LATCH_SENSOR_CHANGED_BIT] =
      sampler_armed & (latch_sensor ^ latch_sensor_prev);

   genvar ev;
   generate
      for (ev = 0; ev < 3; ev = ev + 1) begin : g_event
         reg flag;

         // These flags are read-only, so only reset takes them down again.
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               flag <= 1'b0;
            end else if (event_capable[ev] && event_hit[ev]) begin
               flag <= 1'b1;
            end
         end

         assign event_flags[ev] = flag;
      end
   endgenerate

   assign button_pressed_flag = event_flags[`BUTTON_PRESSED_BIT];
   assign power_fault_flag = event_flags[`POWER_FAULT_BIT];
   assign latch_sensor_changed_flag = event_flags[`LATCH_SENSOR_CHANGED_BIT];

   // ==========================================================
   // Configuration access

   assign reg_hit = cfg_addr == `SLOT_STATUS_OFFSET;
   assign hit_wr = cfg_wr & reg_hit;
   assign hit_rd = cfg_rd & reg_hit;

   // The upper byte holds nothing writable, so byte lane one is ignored.
   assign clear_presence =
      hit_wr & cfg_byte_en[0] & cfg_wdata[`PRESENCE_CHANGED_BIT];

   assign status_word = {9'h000, presence_state, 2'h0, presence_changed_flag,
      latch_sensor_changed_flag, power_fault_flag, button_pressed_flag};

   // Idle and foreign reads return zero, so a stale word is never shown.
   always @* begin
      next_rdata = 16'h0000;
      if (hit_rd) begin
         next_rdata = status_word;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= `SLOT_STATUS_RESET;
      end else begin
         cfg_rdata <= next_rdata;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rd_ack <= 1'b0;
      end else begin
         cfg_rd_ack <= cfg_rd;
      end
   end

endmodule
`default_nettype wire

/* File: verification/slot_status_checker.sv */
`default_nettype none
module slot_status_checker(input wire clk,nrst,slot_implemented,cfg_rd,cfg_rd_ack,
presence_change_notify,
presence_change_notify_enable,input wire[7:0]cfg_addr,input wire[15:0]cfg_rdata);
default clocking @(posedge clk);endclocking
default disable iff(!nrst);
property p_rsv;cfg_rd_ack|->cfg_rdata[15:7]==0&&cfg_rdata[5:4]==0;endproperty
a_rsv:assert property(p_rsv)else $error("fail");
property p_rst;disable iff(1'b0)!nrst|->cfg_rdata==0;endproperty
a_rst:assert property(p_rst)else $error("fail");
property p_ntf;presence_change_notify|->$past(presence_change_notify_enable);endproperty
a_ntf:assert property(p_ntf)else $error("fail");
property p_chg;cfg_rd&&cfg_addr==8'hBA&&presence_change_notify|=>cfg_rdata[3];endproperty
a_chg:assert property(p_chg)else $error("fail");
property p_pds;(!slot_implemented##1(cfg_rd&&cfg_addr==8'hBA&&!slot_implemented))|=>cfg_rdata[6];
endproperty
a_pds:assert property(p_pds)else $error("fail");
property p_map;cfg_rd&&cfg_addr!=8'hBA|=>cfg_rdata==16'h0000;endproperty
a_map:assert property(p_map)else $error("fail");
c_ntf:cover property(presence_change_notify);
c_flt:cover property(cfg_rd_ack&&cfg_rdata[1]);
c_chg:cover property(cfg_rd_ack&&cfg_rdata[3]);
endmodule
bind pcie_slot_status_register slot_status_checker slot_status_checker_inst(.*);
`default_nettype wire

/* File: verification/slot_adapter_model.sv */
`default_nettype none
module slot_adapter_model(input wire[5:0]cmd,output wire inband_presence,oob_presence,
adapter_powered,latch_sensor,power_fault,button);
assign{adapter_powered,oob_presence,latch_sensor,power_fault,button}=cmd[5:1];
assign inband_presence=cmd[0]&cmd[5];
endmodule
`default_nettype wire

/* File: verification/pcie_slot_status_register_tb.sv */
`default_nettype none
module pcie_slot_status_register_tb;
timeunit 1ns;timeprecision 1ns;
logic clk=0,nrst,cfg_wr=0,cfg_rd=0,slot_implemented=0,oob_presence_present=0;
logic latch_sensor_present=0,fault_detect_supported=0,button_present=0;
logic presence_change_notify_enable=1;logic[1:0]cfg_byte_en=0;logic[7:0]cfg_addr=8'hBA;
logic[15:0]cfg_wdata=0;logic[5:0]cmd=0;wire[15:0]cfg_rdata;int bad_count=0,n_tests=0;
wire cfg_rd_ack,presence_change_notify,inband_presence,oob_presence,adapter_powered;
wire latch_sensor,power_fault,button;
always #25 clk=~clk;
pcie_slot_status_register pcie_slot_status_register_inst(.*);
slot_adapter_model slot_adapter_model_inst(.*);
task chk(input logic[15:0]s,e);n_tests++;
if(s!==e)begin bad_count++;$display("BAD %0t %h %h",$time,s,e);end endtask
task rd(input logic[15:0]e);cfg_rd=1;@(negedge clk);cfg_rd=0;chk(cfg_rdata,e);
chk({15'h0000,cfg_rd_ack},16'h0001);@(negedge clk);endtask
task wr(input logic[1:0]b,input logic[15:0]d);cfg_byte_en=b;cfg_wdata=d;cfg_wr=1;
@(negedge clk);cfg_wr=0;endtask
task st(input logic[5:0]c);cmd=c;@(negedge clk);endtask
task report_and_stop;$display("%0d checks, %0d bad",n_tests,bad_count);
if(bad_count==0&&n_tests>0)$display("TB: PASS");else $display("TB: FAIL");$finish;endtask
initial begin nrst=0;repeat(20)@(negedge clk);nrst=1;repeat(3)@(negedge clk);
rd(16'h0048);
wr(2'h2,16'hFFFF);rd(16'h0048);
wr(2'h1,16'h0008);rd(16'h0040);
slot_implemented=1;st(6'h01);chk(presence_change_notify,1);
rd(16'h0008);
oob_presence_present=1;st(6'h10);rd(16'h0048);
{latch_sensor_present,fault_detect_supported,button_present}=3'h7;st(6'h1E);
rd(16'h004F);
presence_change_notify_enable=0;st(6'h00);chk(presence_change_notify,0);
rd(16'h000F);
cfg_addr=8'hBC;rd(16'h0000);
report_and_stop;end
initial begin #20us;bad_count++;report_and_stop;end
endmodule
`default_nettype wire
